// ==== hdl/ebcs_cfg.svh ====
`ifndef EBCS_CFG_SVH
`define EBCS_CFG_SVH
// register offsets on the plain register port
`define EBCS_OFF_RCTL 4'h0
`define EBCS_OFF_RCNT 4'h1
`define EBCS_OFF_RPER 4'h2
`define EBCS_OFF_DACC 4'h3
`define EBCS_OFF_SYSC 4'h4
`define EBCS_OFF_DDR 4'h5
`define EBCS_OFF_STAT 4'h6
`define EBCS_OFF_MASK 4'h7
// reset values
`define EBCS_RST_RCTL 8'h00
`define EBCS_RST_RCNT 8'h00
`define EBCS_RST_RPER 8'hff
`define EBCS_RST_DACC 4'h0
`define EBCS_RST_SYSC 1'h1
`define EBCS_RST_DDR 8'h00
`define EBCS_RST_IRQ 2'h0
// status bit positions
`define EBCS_ST_MATCH 0
`define EBCS_ST_PRECH 1
// clock select code that stops the refresh count
`define EBCS_CKS_STOP 3'h0
// cycles the strap pins must settle after reset release
`define EBCS_STRAP_WAIT 2'h3
// select pin positions reused in continuous sync dram mode
`define EBCS_PIN_RAS 2
`define EBCS_PIN_CAS 3
`define EBCS_PIN_WE 4
`define EBCS_PIN_CLK 5
`define EBCS_DRAM_LO 3'h2
`define EBCS_DRAM_HI 3'h5
`define EBCS_AREA_ROM_OUT 0
`define EBCS_AREA_RAMIO 3'h7
`endif

// ==== hdl/ebcs_pkg.sv ====
package ebcs_pkg;
    // use of areas 2 to 5
    typedef enum logic [1:0] {
        EBCS_A25_NORMAL,
        EBCS_A25_DRAM,
        EBCS_A25_SDRAM,
        EBCS_A25_RSVD
    } ebcs_a25_t;
    // refresh_control layout
    typedef struct packed {
        logic [2:0] prech_ext;
        logic match_irq_enable;
        logic refresh_enable;
        logic [2:0] clk_sel;
    } ebcs_rctl_t;
    // dram_access_control layout (upper four bits read zero)
    typedef struct packed {
        ebcs_a25_t area25_kind;
        logic [1:0] precharge_cycles;
    } ebcs_dacc_t;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ebcs_bus_t;
    // sync dram pin bundle from the access sequencer
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic clk;
        logic cke;
    } ebcs_sd_t;
    // whole state of the block
    typedef struct packed {
        ebcs_rctl_t rctl;
        logic [7:0] rcnt;
        logic [7:0] rper;
        ebcs_dacc_t dacc;
        logic ram_en;
        logic [7:0] ddr;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [6:0] presc;
        logic [3:0] prech;
        logic prech_ext_run;
        logic refresh_start;
        logic [7:0] rdata;
        logic [7:0] sel_n;
        logic [7:0] sel_oe;
        logic oe_n;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] strap_cnt;
        logic exp_mode;
        logic irq;
    } ebcs_state_t;
endpackage

// ==== hdl/ebcs_top.sv ====
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "ebcs_cfg.svh"
// Notes on behaviour
// - eight-bit counter advances on selected clock tap
// - match sets flag and clears counter
// - match with refresh enabled starts refresh
// - match, refresh off, irq enabled: interrupt
// - counter zeroed by reset and hardware standby
// - period resets to ones, kept in soft standby
// - sync dram mode reuses selects and output enable
// - area six external, basic interface, select out
// - area seven io, and ram while enabled, internal, rest external
// - area seven external uses basic interface, select
// - eight active-low selects, low during access
// - select reaches pin only when direction enables
// - rom off, expanded mode: area zero output after reset
// - rom on: all selects inputs after reset
// - dram mode: selects two-five are row strobes
// - extension adds zero to seven precharge states
// - normal precharge follows two-bit setting
module ebcs_top
    import ebcs_pkg::*;
(
    input wire logic MCLK, // 10 MHz clock
    input wire logic RST_B, // async reset, active low
    input wire logic CE, // clock enable, freezes all state
    input wire logic HW_STANDBY, // hardware standby, reinitialises
    input wire logic SW_STANDBY, // software standby, holds count
    input wire logic MODE_EXP, // strap pin: externally expanded mode
    input wire logic ROM_EN, // strap pin: on-chip rom enabled
    input wire logic [3:0] ADDR, // register address
    input wire logic [7:0] WDATA, // register write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [7:0] RDATA, // read data, cycle after strobe
    output logic IRQ, // level interrupt
    output logic REFRESH_START, // one-cycle refresh request
    input wire logic ACC_REQ, // bus access in progress
    input wire logic [2:0] ACC_AREA, // area of the access
    input wire logic ACC_RAM_HIT, // address falls on on-chip ram
    input wire logic ACC_IO_HIT, // address falls on internal io
    output logic ACC_EXTERNAL, // access goes to external space
    output logic ACC_BASIC_ONLY, // only basic bus interface allowed
    input wire logic DRAM_RAS_N, // row strobe from dram sequencer
    input wire ebcs_sd_t SD_IN, // sync dram pins from sequencer
    input wire logic OE_N_IN, // normal read strobe from sequencer
    input wire logic SELF_REFRESH_EXIT, // pulse: self refresh ended
    input wire logic PRECHARGE_REQ, // pulse: normal precharge starts
    output logic PRECHARGE_BUSY, // row precharge in progress
    output logic [7:0] AREA_SEL_N, // area select pin values
    output logic [7:0] AREA_SEL_OE, // area select output enables
    output logic OE_N // read strobe or clock enable pin
);

    ebcs_state_t st;
    ebcs_state_t next_st;
    ebcs_bus_t bus;
    logic tick;
    logic match;
    logic ext_acc;
    logic [7:0] area_hit;
    logic [7:0] sel_val;
    logic [3:0] ext_total;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // tap of the prescaler for a clock select code, divide by two**sel
    function automatic logic tap_tick(input logic [2:0] sel,
                                      input logic [6:0] presc);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        tap_tick = (sel != `EBCS_CKS_STOP) && ((presc & m) == m);
    endfunction

    // true when the area is one of the dram capable areas
    function automatic logic is_dram_area(input logic [2:0] area);
        is_dram_area = (area >= `EBCS_DRAM_LO) && (area <= `EBCS_DRAM_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // combinational decode

    // gather register port signals
    always_comb begin
        bus.addr = ADDR;
        bus.wdata = WDATA;
        bus.wr = WR;
        bus.rd = RD;
    end

    // refresh timebase and compare
    always_comb begin
        tick = tap_tick(st.rctl.clk_sel, st.presc) && !SW_STANDBY;
        match = tick && (st.rcnt == st.rper);
    end

    // address space decode for the current access
    always_comb begin
        ext_acc = ACC_REQ && st.exp_mode;
        if (ACC_AREA == `EBCS_AREA_RAMIO) begin
            if (ACC_IO_HIT || (ACC_RAM_HIT && st.ram_en)) begin
                ext_acc = 1'b0;
            end
        end
    end

    // per-area hit vector
    always_comb begin
        area_hit = 8'h00;
        if (ext_acc) begin
            area_hit[ACC_AREA] = 1'b1;
        end
    end

    // select pin values per area
    for (genvar g = 0; g < 8; g++) begin : g_sel
        logic v;
        // one process per bit, its own variable, so no bit has two writers
        always_comb begin
            v = !area_hit[g];
            if (is_dram_area(3'(g))) begin
                if (st.dacc.area25_kind == EBCS_A25_DRAM) begin
                    v = !area_hit[g] || DRAM_RAS_N;
                end else if (st.dacc.area25_kind == EBCS_A25_SDRAM) begin
                    case (g)
                        `EBCS_PIN_RAS: v = SD_IN.ras_n;
                        `EBCS_PIN_CAS: v = SD_IN.cas_n;
                        `EBCS_PIN_WE: v = SD_IN.we_n;
                        `EBCS_PIN_CLK: v = SD_IN.clk;
                        default: v = !area_hit[g];
                    endcase
                end
            end
        end
        assign sel_val[g] = v;
    end

    // total precharge after self refresh: normal plus extension
    always_comb begin
        ext_total = 4'(st.dacc.precharge_cycles) + 4'h1
            + 4'(st.rctl.prech_ext);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.refresh_start = 1'b0;
        // strap pins pass three flops; a level counts when two agree
        next_st.s1 = {MODE_EXP, ROM_EN};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.exp_mode = st.s3[1];
        end
        // direction bits caught from the straps once they settle
        // only edges with the last two flops agreeing count towards it
        if ((st.strap_cnt != `EBCS_STRAP_WAIT) && (st.s2 == st.s3)) begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
            if (st.strap_cnt + 2'h1 == `EBCS_STRAP_WAIT) begin
                next_st.ddr = `EBCS_RST_DDR;
                next_st.ddr[`EBCS_AREA_ROM_OUT] =
                    st.s3[1] && !st.s3[0];
            end
        end
        // prescaler runs except in software standby
        if (!SW_STANDBY) begin
            next_st.presc = st.presc + 7'h01;
        end
        // refresh counter; compare clear wins over a write
        if (bus.wr && bus.addr == `EBCS_OFF_RCNT) begin
            next_st.rcnt = bus.wdata;
        end
        if (match) begin
            next_st.rcnt = `EBCS_RST_RCNT;
            next_st.refresh_start = st.rctl.refresh_enable;
        end else if (tick && !(bus.wr && bus.addr == `EBCS_OFF_RCNT)) begin
            next_st.rcnt = st.rcnt + 8'h01;
        end
        // precharge timing
        if (st.prech != 4'h0) begin
            next_st.prech = st.prech - 4'h1;
        end
        if (SELF_REFRESH_EXIT) begin
            next_st.prech = ext_total;
            next_st.prech_ext_run = 1'b1;
        end else if (PRECHARGE_REQ) begin
            next_st.prech = 4'(st.dacc.precharge_cycles) + 4'h1;
            next_st.prech_ext_run = 1'b0;
        end else if (st.prech == 4'h1) begin
            next_st.prech_ext_run = 1'b0;
        end
        // register writes
        if (bus.wr) begin
            case (bus.addr)
                `EBCS_OFF_RCTL: next_st.rctl = ebcs_rctl_t'(bus.wdata);
                `EBCS_OFF_RPER: next_st.rper = bus.wdata;
                `EBCS_OFF_DACC: next_st.dacc = ebcs_dacc_t'(bus.wdata[3:0]);
                `EBCS_OFF_SYSC: next_st.ram_en = bus.wdata[0];
                `EBCS_OFF_DDR: next_st.ddr = bus.wdata;
                `EBCS_OFF_STAT: next_st.stat = st.stat & ~bus.wdata[1:0];
                `EBCS_OFF_MASK: next_st.mask = bus.wdata[1:0];
                default: next_st.stat = next_st.stat;
            endcase
        end
        // events set status bits; set wins over a clear
        if (match) begin
            next_st.stat[`EBCS_ST_MATCH] = 1'b1;
        end
        if (st.prech_ext_run && st.prech == 4'h1) begin
            next_st.stat[`EBCS_ST_PRECH] = 1'b1;
        end
        // read data stands in the cycle after the strobe only
        next_st.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `EBCS_OFF_RCTL: next_st.rdata = st.rctl;
                `EBCS_OFF_RCNT: next_st.rdata = st.rcnt;
                `EBCS_OFF_RPER: next_st.rdata = st.rper;
                `EBCS_OFF_DACC: next_st.rdata = {4'h0, st.dacc};
                `EBCS_OFF_SYSC: next_st.rdata = {7'h00, st.ram_en};
                `EBCS_OFF_DDR: next_st.rdata = st.ddr;
                `EBCS_OFF_STAT: next_st.rdata = {6'h00, st.stat};
                `EBCS_OFF_MASK: next_st.rdata = {6'h00, st.mask};
                default: next_st.rdata = 8'h00;
            endcase
        end
        // interrupt: match bit only while refresh is off and enabled
        next_st.irq = (next_st.stat[`EBCS_ST_MATCH]
            && next_st.mask[`EBCS_ST_MATCH]
            && !next_st.rctl.refresh_enable
            && next_st.rctl.match_irq_enable)
            || (next_st.stat[`EBCS_ST_PRECH]
            && next_st.mask[`EBCS_ST_PRECH]);
        // pins: selects reach out only where direction enables
        next_st.sel_oe = st.ddr;
        next_st.sel_n = sel_val;
        next_st.oe_n = (st.dacc.area25_kind == EBCS_A25_SDRAM)
            ? SD_IN.cke : OE_N_IN;
        // hardware standby reinitialises the refresh and interrupt registers
        if (HW_STANDBY) begin
            next_st.rcnt = `EBCS_RST_RCNT;
            next_st.rper = `EBCS_RST_RPER;
            next_st.rctl = ebcs_rctl_t'(`EBCS_RST_RCTL);
            next_st.stat = `EBCS_RST_IRQ;
            next_st.mask = `EBCS_RST_IRQ;
            next_st.irq = 1'b0;
            next_st.refresh_start = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= '0;
            st.rctl <= ebcs_rctl_t'(`EBCS_RST_RCTL);
            st.rcnt <= `EBCS_RST_RCNT;
            st.rper <= `EBCS_RST_RPER;
            st.dacc <= ebcs_dacc_t'(`EBCS_RST_DACC);
            st.ram_en <= `EBCS_RST_SYSC;
            st.ddr <= `EBCS_RST_DDR;
            st.sel_n <= 8'hff;
        end else if (CE) begin
            st <= next_st;
        end
    end

    // outputs
    assign RDATA = st.rdata;
    assign IRQ = st.irq;
    assign REFRESH_START = st.refresh_start;
    assign PRECHARGE_BUSY = st.prech != 4'h0;
    assign AREA_SEL_N = st.sel_n;
    assign AREA_SEL_OE = st.sel_oe;
    assign OE_N = st.oe_n;
    assign ACC_EXTERNAL = ext_acc;
    assign ACC_BASIC_ONLY = ext_acc && (ACC_AREA >= 3'h6);

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_match_clears_cnt: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && match && !HW_STANDBY) |=> st.rcnt == 8'h00)
        else $error("counter not cleared after match");

    a_match_sets_flag: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && match && !HW_STANDBY) |=> st.stat[0])
        else $error("match flag not set");

    a_refresh_on_match: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        REFRESH_START |-> $past(match) && $past(st.rctl.refresh_enable))
        else $error("refresh start without enabled match");

    a_irq_gating: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (IRQ && !st.stat[1]) |-> !st.rctl.refresh_enable
            && st.rctl.match_irq_enable)
        else $error("interrupt while refresh enabled");

    a_irq_raise: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && !WR && !HW_STANDBY && st.stat[0] && st.mask[0]
            && !st.rctl.refresh_enable && st.rctl.match_irq_enable) |=> IRQ)
        else $error("enabled match did not interrupt");

    a_count_step: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && tick && !match && !WR && !HW_STANDBY)
            |=> st.rcnt == $past(st.rcnt) + 8'h01)
        else $error("counter did not advance on tick");

    a_stop_holds: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && st.rctl.clk_sel == 3'h0 && !WR && !HW_STANDBY)
            |=> $stable(st.rcnt))
        else $error("counter moved with clock stopped");

    a_soft_hold: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && SW_STANDBY && !WR && !HW_STANDBY) |=> $stable(st.rcnt))
        else $error("counter moved in software standby");

    a_standby_init: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && HW_STANDBY) |=> st.rcnt == 8'h00 && st.rper == 8'hff)
        else $error("standby did not reinitialise");

    a_sel_idle_high: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && !ACC_REQ && st.dacc.area25_kind == EBCS_A25_NORMAL)
            |=> AREA_SEL_N == 8'hff)
        else $error("select low without access");

    a_ramio_internal: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (ACC_AREA == 3'h7 && (ACC_IO_HIT || (ACC_RAM_HIT && st.ram_en)))
            |-> !ACC_EXTERNAL)
        else $error("internal area seven access went external");

    a_dram_row_strobe: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && st.dacc.area25_kind == EBCS_A25_DRAM && DRAM_RAS_N)
            |=> AREA_SEL_N[5:2] == 4'hf)
        else $error("row strobe select low while strobe idle");

    a_sdram_pins: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && st.dacc.area25_kind == EBCS_A25_SDRAM)
            |=> OE_N == $past(SD_IN.cke) && AREA_SEL_N[5:2] ==
            $past({SD_IN.clk, SD_IN.we_n, SD_IN.cas_n, SD_IN.ras_n}))
        else $error("sync dram pins not routed");

    a_prech_length: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && SELF_REFRESH_EXIT) |=> st.prech == $past(ext_total))
        else $error("extended precharge length wrong");

    a_prech_normal: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (CE && PRECHARGE_REQ && !SELF_REFRESH_EXIT)
            |=> st.prech == 4'($past(st.dacc.precharge_cycles)) + 4'h1)
        else $error("normal precharge length wrong");

    a_sel_dir: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        CE |=> AREA_SEL_OE == $past(st.ddr))
        else $error("select enable does not follow direction");

endmodule // ebcs_top

// ==== tb/ebcs_mem_model.sv ====
`timescale 1ns/10ps
// memory side of the select pins: pulled-up wires seen by the memories
module ebcs_mem_model (
    input wire logic [7:0] sel_n, // select pin values
    input wire logic [7:0] sel_oe, // select output enables
    output logic [7:0] pin // resolved select wires
);
    // an undriven select floats to the pull-up level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = sel_oe[i] ? sel_n[i] : 1'h1;
        end
    end
endmodule // ebcs_mem_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "ebcs_cfg.svh"
module tb_top;
    import ebcs_pkg::*;
    logic mclk, rst_b, ce, hw_sb, sw_sb, mode_exp, rom_en, wr, rd, irq, rfs;
    logic acc_req, ram_hit, io_hit, acc_ext, basic, ras_n, oe_n_in, oe_n;
    logic sr_exit, pre_req, busy;
    logic [3:0] addr;
    logic [2:0] acc_area;
    logic [7:0] wdata, rdata, sel_n, sel_oe, pin, v, ddr_now;
    ebcs_sd_t sd_in;
    int bad_count, cmp_count;

    ebcs_top dut (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .HW_STANDBY(hw_sb),
        .SW_STANDBY(sw_sb), .MODE_EXP(mode_exp), .ROM_EN(rom_en),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq), .REFRESH_START(rfs), .ACC_REQ(acc_req),
        .ACC_AREA(acc_area), .ACC_RAM_HIT(ram_hit), .ACC_IO_HIT(io_hit),
        .ACC_EXTERNAL(acc_ext), .ACC_BASIC_ONLY(basic),
        .DRAM_RAS_N(ras_n), .SD_IN(sd_in), .OE_N_IN(oe_n_in),
        .SELF_REFRESH_EXIT(sr_exit), .PRECHARGE_REQ(pre_req),
        .PRECHARGE_BUSY(busy), .AREA_SEL_N(sel_n), .AREA_SEL_OE(sel_oe),
        .OE_N(oe_n));
    ebcs_mem_model mem (.sel_n(sel_n), .sel_oe(sel_oe), .pin(pin));

    // 10 MHz clock
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    // compare, verdict and register port helpers
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task cycles(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task reg_wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        @(posedge mclk);
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] e, input string s);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        @(negedge mclk);
        v = rdata;
        chk(s, v, e);
        @(posedge mclk);
    endtask
    task do_reset(input logic m, input logic r);
        rst_b <= 1'h0;
        mode_exp <= m;
        rom_en <= r;
        cycles(16);
        rst_b <= 1'h1;
        cycles(5);
    endtask
    // one access: combinational routing, then the registered select
    task acc(input logic [2:0] ar, input logic ram, input logic io,
             input logic ext, input logic [7:0] exp);
        acc_req <= 1'h1;
        acc_area <= ar;
        ram_hit <= ram;
        io_hit <= io;
        @(negedge mclk);
        chk("external", {7'h0, acc_ext}, {7'h0, ext});
        chk("basic", {7'h0, basic}, {7'h0, ext && ar >= 3'h6});
        @(negedge mclk);
        chk("select", sel_n, exp);
        chk("pin", pin, exp | ~ddr_now);
        @(posedge mclk);
        acc_req <= 1'h0;
        cycles(1);
        @(negedge mclk);
        chk("idle select", sel_n, 8'hff);
        @(posedge mclk);
    endtask
    task pre(input logic ex, input int exp);
        int cnt;
        cnt = 0;
        if (ex) sr_exit <= 1'h1;
        else pre_req <= 1'h1;
        @(posedge mclk);
        sr_exit <= 1'h0;
        pre_req <= 1'h0;
        repeat (14) begin
            @(negedge mclk);
            if (busy === 1'h1) cnt++;
        end
        chk("busy cycles", 8'(cnt), 8'(exp));
        @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////
    // scenarios
    task t_reset_vals;
        rd_chk(`EBCS_OFF_RCNT, 8'h00, "count");
        rd_chk(`EBCS_OFF_RPER, 8'hff, "period");
        @(negedge mclk);
        chk("rdata idle", rdata, 8'h00);
        @(posedge mclk);
        rd_chk(`EBCS_OFF_SYSC, 8'h01, "ram enable");
        rd_chk(`EBCS_OFF_DDR, 8'h01, "direction");
        chk("sel oe", sel_oe, 8'h01);
        rd_chk(4'h9, 8'h00, "unmapped");
    endtask
    task t_refresh;
        int a, b, n;
        a = -1;
        b = -1;
        reg_wr(`EBCS_OFF_RPER, 8'h03);
        reg_wr(`EBCS_OFF_RCTL, 8'h0a);
        for (n = 0; n < 80 && b < 0; n++) begin
            @(negedge mclk);
            if (rfs === 1'h1 && a < 0) a = n;
            else if (rfs === 1'h1) b = n;
        end
        @(posedge mclk);
        if (b < 0) begin
            chk("refresh wait", 8'h00, 8'h01);
            tally_and_finish();
        end
        chk("refresh gap", 8'(b - a), 8'h10);
        reg_wr(`EBCS_OFF_RCTL, 8'h08);
        rd_chk(`EBCS_OFF_STAT, 8'h01, "match flag");
        rd_chk(`EBCS_OFF_RCNT, 8'h00, "count probe");
        cycles(6);
        rd_chk(`EBCS_OFF_RCNT, v, "stopped");
        reg_wr(`EBCS_OFF_STAT, 8'h01);
        rd_chk(`EBCS_OFF_STAT, 8'h00, "flag cleared");
    endtask
    task t_irq;
        int hit;
        hit = 0;
        reg_wr(`EBCS_OFF_RCTL, 8'h11);
        repeat (20) begin
            @(negedge mclk);
            if (irq !== 1'h0 || rfs !== 1'h0) hit++;
        end
        chk("masked", 8'(hit), 8'h00);
        @(posedge mclk);
        reg_wr(`EBCS_OFF_RCTL, 8'h10);
        rd_chk(`EBCS_OFF_STAT, 8'h01, "irq flag");
        reg_wr(`EBCS_OFF_MASK, 8'h01);
        @(negedge mclk);
        chk("irq raised", {7'h0, irq}, 8'h01);
        @(posedge mclk);
        reg_wr(`EBCS_OFF_STAT, 8'h01);
        @(negedge mclk);
        chk("irq cleared", {7'h0, irq}, 8'h00);
        @(posedge mclk);
    endtask
    task t_select;
        reg_wr(`EBCS_OFF_DDR, 8'hff);
        ddr_now = 8'hff;
        for (int i = 0; i < 7; i++) acc(3'(i), 1'h0, 1'h0, 1'h1, ~(8'h01 << i));
        acc(3'h7, 1'h0, 1'h1, 1'h0, 8'hff);
        acc(3'h7, 1'h1, 1'h0, 1'h0, 8'hff);
        acc(3'h7, 1'h0, 1'h0, 1'h1, 8'h7f);
        reg_wr(`EBCS_OFF_SYSC, 8'h00);
        acc(3'h7, 1'h1, 1'h0, 1'h1, 8'h7f);
        reg_wr(`EBCS_OFF_DDR, 8'hbf);
        ddr_now = 8'hbf;
        acc(3'h6, 1'h0, 1'h0, 1'h1, 8'hbf);
    endtask
    task t_dram;
        logic [4:0] p;
        reg_wr(`EBCS_OFF_DACC, 8'h04);
        ras_n <= 1'h0;
        acc(3'h3, 1'h0, 1'h0, 1'h1, 8'hf7);
        ras_n <= 1'h1;
        acc(3'h3, 1'h0, 1'h0, 1'h1, 8'hff);
        reg_wr(`EBCS_OFF_DACC, 8'h08);
        for (int k = 0; k < 2; k++) begin
            p = k ? 5'h15 : 5'h0a;
            sd_in <= p;
            oe_n_in <= ~p[0];
            cycles(2);
            @(negedge mclk);
            chk("sd pins", {4'h0, sel_n[5:2]}, {4'h0, p[1], p[2], p[3], p[4]});
            chk("cke pin", {7'h0, oe_n}, {7'h0, p[0]});
            @(posedge mclk);
        end
    endtask
    task t_prech;
        reg_wr(`EBCS_OFF_DACC, 8'h01);
        for (int e = 1; e < 8; e += 3) begin
            reg_wr(`EBCS_OFF_RCTL, {3'(e), 5'h00});
            pre(1'h1, 2 + e);
        end
        rd_chk(`EBCS_OFF_STAT, 8'h02, "ext done");
        pre(1'h0, 2);
        reg_wr(`EBCS_OFF_DACC, 8'h03);
        pre(1'h1, 11);
    endtask
    task t_standby;
        reg_wr(`EBCS_OFF_RPER, 8'h80);
        reg_wr(`EBCS_OFF_RCNT, 8'h12);
        rd_chk(`EBCS_OFF_RCNT, 8'h12, "count rw");
        sw_sb <= 1'h1;
        reg_wr(`EBCS_OFF_RCTL, 8'h01);
        cycles(2);
        rd_chk(`EBCS_OFF_RCNT, 8'h12, "count probe");
        cycles(8);
        rd_chk(`EBCS_OFF_RCNT, 8'h12, "soft hold");
        rd_chk(`EBCS_OFF_RPER, 8'h80, "period kept");
        sw_sb <= 1'h0;
        hw_sb <= 1'h1;
        cycles(2);
        hw_sb <= 1'h0;
        rd_chk(`EBCS_OFF_RCNT, 8'h00, "hard count");
        rd_chk(`EBCS_OFF_RPER, 8'hff, "hard period");
    endtask
    task t_straps;
        do_reset(1'h1, 1'h1);
        chk("rom sel oe", sel_oe, 8'h00);
        rd_chk(`EBCS_OFF_DDR, 8'h00, "rom dir");
        do_reset(1'h0, 1'h0);
        ddr_now = 8'h00;
        acc(3'h0, 1'h0, 1'h0, 1'h0, 8'hff);
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_b, hw_sb, sw_sb, wr, rd, acc_req, ram_hit, io_hit} = '0;
        {sr_exit, pre_req, addr, wdata, acc_area} = '0;
        {mode_exp, rom_en, ras_n, oe_n_in, ce} = 5'h1b;
        sd_in = '1;
        ddr_now = 8'h01;
        bad_count = 0;
        cmp_count = 0;
        do_reset(1'h1, 1'h0);
        t_reset_vals();
        t_refresh();
        t_irq();
        t_select();
        t_dram();
        t_prech();
        t_standby();
        t_straps();
        tally_and_finish();
    end
endmodule // tb_top
